/* File: src/tsc_pkg.sv */
// Purpose: constants for the timer channel sync control block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: one register, low byte holds the sync bits
package tsc_pkg;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int unsigned NUM_CH = 5;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 8;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] SYNC_SELECT_OFFSET = 8'h00;
    localparam logic [7:0] SYNC_SELECT_RESET = 8'h00;
    localparam logic [7:0] SYNC_SELECT_WMASK = 8'hC7;
    localparam int unsigned CH4_SYNC_POS = 7;
    localparam int unsigned CH3_SYNC_POS = 6;
    localparam int unsigned CH2_SYNC_POS = 2;
    localparam int unsigned CH1_SYNC_POS = 1;
    localparam int unsigned CH0_SYNC_POS = 0;
    // ----------------------------------------
    // clear source code meaning synchronous clear
    // ----------------------------------------
    localparam logic [2:0] CLR_SRC_SYNC = 3'h3;
endpackage : tsc_pkg

/* File: src/tsc_bit_map.sv */
// Purpose: maps register byte to per-channel sync flags
// Assumes: fixed bit positions from the package
// Notes: pure combinational
`timescale 1ns/10ps
module tsc_bit_map (
    input wire logic [7:0] reg_i,
    output logic [4:0] flags_o
);
    always_comb begin
        flags_o[4] = reg_i[tsc_pkg::CH4_SYNC_POS];
        flags_o[3] = reg_i[tsc_pkg::CH3_SYNC_POS];
        flags_o[2] = reg_i[tsc_pkg::CH2_SYNC_POS];
        flags_o[1] = reg_i[tsc_pkg::CH1_SYNC_POS];
        flags_o[0] = reg_i[tsc_pkg::CH0_SYNC_POS];
    end
endmodule : tsc_bit_map

/* File: src/tsc_wb_slave.sv */
// Purpose: classic wishbone slave for the sync register
// Assumes: one wait state, ack one cycle
// Notes: unmapped reads return zero, writes ignored
`timescale 1ns/10ps
module tsc_wb_slave (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [7:0] reg_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic wr_o,
    output logic [7:0] wdata_o
);
    logic hit;
    logic req;
    assign hit = (adr_i[7:2] == tsc_pkg::SYNC_SELECT_OFFSET[7:2]);
    assign req = cyc_i && stb_i && !ack_o;
    // ----------------------------------------
    // ack and read data
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            if (req && !we_i && hit) begin
                dat_o <= {24'h000000, reg_i & tsc_pkg::SYNC_SELECT_WMASK};
            end else begin
                dat_o <= 32'h00000000;
            end
        end
    end
    // ----------------------------------------
    // write strobe toward register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_o <= 1'b0;
            wdata_o <= 8'h00;
        end else begin
            wr_o <= req && we_i && hit && sel_i[0];
            wdata_o <= dat_i[7:0];
        end
    end
endmodule : tsc_wb_slave

/* File: src/tsc_sync_ctrl.sv */
// Purpose: timer channel synchronous preset and clear control
// Assumes: counters live outside; they obey load and clear outputs
// Notes: all outputs registered, one cycle after the cause
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
module tsc_sync_ctrl #(
    parameter int unsigned NUM_CH = tsc_pkg::NUM_CH,
    parameter int unsigned CNT_W = tsc_pkg::CNT_W
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_CH-1:0] cnt_wr_i,
    input wire logic [NUM_CH*CNT_W-1:0] cnt_wdata_i,
    input wire logic [NUM_CH*3-1:0] clr_src_i,
    input wire logic [NUM_CH-1:0] clr_event_i,
    output logic [NUM_CH-1:0] cnt_load_o,
    output logic [NUM_CH*CNT_W-1:0] cnt_load_data_o,
    output logic [NUM_CH-1:0] cnt_clear_o,
    output logic [7:0] sync_select_o
);
    logic [7:0] channel_sync_select;
    logic [4:0] sync_flags;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [NUM_CH-1:0] next_load;
    logic [NUM_CH-1:0] next_clear;
    logic [NUM_CH*CNT_W-1:0] next_data;
    logic sync_wr_any;
    logic sync_clr_any;
    logic [CNT_W-1:0] sync_value;

    function automatic logic [CNT_W-1:0] pick_word(
        input logic [NUM_CH*CNT_W-1:0] bus,
        input int unsigned idx
    );
        pick_word = bus[idx*CNT_W +: CNT_W];
    endfunction : pick_word

    // ----------------------------------------
    // bus slave and bit map
    // ----------------------------------------
    tsc_wb_slave u_slave (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .cyc_i(wb_cyc_i),
        .stb_i(wb_stb_i),
        .we_i(wb_we_i),
        .adr_i(wb_adr_i),
        .sel_i(wb_sel_i),
        .dat_i(wb_dat_i),
        .reg_i(channel_sync_select),
        .dat_o(wb_dat_o),
        .ack_o(wb_ack_o),
        .wr_o(reg_wr),
        .wdata_o(reg_wdata)
    );

    tsc_bit_map u_map (
        .reg_i(channel_sync_select),
        .flags_o(sync_flags)
    );

    // ----------------------------------------
    // sync select register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            channel_sync_select <= tsc_pkg::SYNC_SELECT_RESET;
        end else if (reg_wr) begin
            channel_sync_select <= reg_wdata & tsc_pkg::SYNC_SELECT_WMASK;
        end
    end

    // ----------------------------------------
    // preset and clear fan-out
    // ----------------------------------------
    always_comb begin
        sync_wr_any = 1'b0;
        sync_clr_any = 1'b0;
        sync_value = '0;
        // lowest flagged writer wins when several write at once
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (cnt_wr_i[i] && sync_flags[i]) begin
                sync_wr_any = 1'b1;
                sync_value = pick_word(cnt_wdata_i, i);
            end
            if (clr_event_i[i] && sync_flags[i]) begin
                sync_clr_any = 1'b1;
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (sync_flags[i]) begin
                next_load[i] = sync_wr_any;
                next_data[i*CNT_W +: CNT_W] = sync_wr_any ? sync_value
                                                          : pick_word(cnt_wdata_i, i);
                next_clear[i] = clr_event_i[i] ||
                    (sync_clr_any && clr_src_i[i*3 +: 3] == tsc_pkg::CLR_SRC_SYNC);
            end else begin
                next_load[i] = cnt_wr_i[i];
                next_data[i*CNT_W +: CNT_W] = pick_word(cnt_wdata_i, i);
                next_clear[i] = clr_event_i[i];
            end
        end
    end

    // ----------------------------------------
    // registered outputs, one shared edge
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_load_o <= '0;
            cnt_clear_o <= '0;
            cnt_load_data_o <= '0;
        end else begin
            cnt_load_o <= next_load;
            cnt_clear_o <= next_clear;
            cnt_load_data_o <= next_data;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_select_o <= tsc_pkg::SYNC_SELECT_RESET;
        end else begin
            sync_select_o <= channel_sync_select;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_sync_write(int ch);
        cnt_wr_i[ch] && sync_flags[ch];
    endsequence

    a_reserved_read_zero: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wb_ack_o |-> wb_dat_o[5:3] == 3'h0)
        else $error("reserved bits read nonzero");

    a_reg_write_lands: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        reg_wr |=> channel_sync_select == (($past(reg_wdata)) & tsc_pkg::SYNC_SELECT_WMASK))
        else $error("register write lost");

    a_preset_ch0_fans: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_sync_write(0) |=> (cnt_load_o & $past(sync_flags)) == $past(sync_flags))
        else $error("sync preset missed a channel");

    a_preset_same_value: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_sync_write(0) ##0 (sync_flags[1] && !cnt_wr_i[1] && !cnt_wr_i[2]
         && !cnt_wr_i[3] && !cnt_wr_i[4])
        |=> cnt_load_data_o[CNT_W +: CNT_W] == cnt_load_data_o[0 +: CNT_W])
        else $error("synced presets differ");

    a_unflagged_isolated: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !sync_flags[1] && !cnt_wr_i[1] && !clr_event_i[1]
        |=> !cnt_load_o[1] && !cnt_clear_o[1])
        else $error("unflagged channel disturbed");

    a_sync_clear_follow: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clr_event_i[0] && sync_flags[0] && sync_flags[3]
        && clr_src_i[11:9] == tsc_pkg::CLR_SRC_SYNC |=> cnt_clear_o[3])
        else $error("sync clear not followed");

    a_flag_bits_map: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        sync_flags[4] == channel_sync_select[7] && sync_flags[3] == channel_sync_select[6])
        else $error("high flag mapping wrong");

    a_low_flag_map: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        sync_flags[2:0] == channel_sync_select[2:0])
        else $error("low flag mapping wrong");

    a_ack_one_cycle: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    // ----------------------------------------
    // bus and clear sequences
    // ----------------------------------------
    sequence s_bus_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_reg_write_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i[7:2] == tsc_pkg::SYNC_SELECT_OFFSET[7:2];
    endsequence

    sequence s_reg_read_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i[7:2] == tsc_pkg::SYNC_SELECT_OFFSET[7:2];
    endsequence

    sequence s_write_lands;
        reg_wr ##1 channel_sync_select
            == ($past(wb_dat_i[7:0], 2) & tsc_pkg::SYNC_SELECT_WMASK);
    endsequence

    sequence s_sync_clear(int ch);
        clr_event_i[ch] && sync_flags[ch];
    endsequence

    a_ack_after_take: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_bus_take |=> wb_ack_o)
        else $error("bus request not acked");

    a_no_ack_idle: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !wb_cyc_i |=> !wb_ack_o)
        else $error("ack without request");

    a_write_then_lands: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_reg_write_take |=> s_write_lands)
        else $error("bus write did not land");

    a_read_returns_reg: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_reg_read_take |=> wb_dat_o[7:0] == ($past(channel_sync_select) & tsc_pkg::SYNC_SELECT_WMASK))
        else $error("read data wrong");

    a_read_upper_zero: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits nonzero");

    a_masked_write_drop: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !wb_sel_i[0]
        |=> ##1 $stable(channel_sync_select))
        else $error("masked write changed register");

    a_unmapped_write_drop: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
        && wb_adr_i[7:2] != tsc_pkg::SYNC_SELECT_OFFSET[7:2]
        |=> ##1 $stable(channel_sync_select))
        else $error("unmapped write changed register");

    a_reserved_stay_zero: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        channel_sync_select[5:3] == 3'h0)
        else $error("reserved bits set");

    a_no_write_no_load: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cnt_wr_i == '0 |=> cnt_load_o == '0)
        else $error("load without any write");

    a_own_write_loads: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        cnt_wr_i[4] |=> cnt_load_o[4])
        else $error("own write not loaded");

    a_own_clear_passes: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        clr_event_i[2] |=> cnt_clear_o[2])
        else $error("own clear dropped");

    a_sync_clear_ch0: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_sync_clear(3) ##0 (sync_flags[0] && clr_src_i[2:0] == tsc_pkg::CLR_SRC_SYNC)
        |=> cnt_clear_o[0])
        else $error("sync clear missed channel 0");

    a_other_src_holds: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_sync_clear(0) ##0 (!clr_event_i[1] && clr_src_i[5:3] != tsc_pkg::CLR_SRC_SYNC)
        |=> !cnt_clear_o[1])
        else $error("clear without sync source");

    a_unflagged_no_load: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !sync_flags[2] && !cnt_wr_i[2] |=> !cnt_load_o[2])
        else $error("unflagged channel loaded");

    a_unflagged_own_data: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        !sync_flags[2] && cnt_wr_i[2]
        |=> cnt_load_data_o[2*CNT_W +: CNT_W] == $past(cnt_wdata_i[2*CNT_W +: CNT_W]))
        else $error("unflagged load value wrong");

    a_lowest_value_wins: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_sync_write(0) ##0 sync_flags[4]
        |=> cnt_load_data_o[4*CNT_W +: CNT_W] == $past(cnt_wdata_i[0 +: CNT_W]))
        else $error("preset value not shared");

    a_flagged_load_equal: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> (cnt_load_o & $past(sync_flags)) == '0
            || (cnt_load_o & $past(sync_flags)) == $past(sync_flags))
        else $error("flagged loads split");

    a_flagged_clear_cycle: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        s_sync_clear(0) ##0 (sync_flags[4] && clr_src_i[14:12] == tsc_pkg::CLR_SRC_SYNC)
        |=> cnt_clear_o[0] && cnt_clear_o[4])
        else $error("flagged clears split");
endmodule : tsc_sync_ctrl

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the timer channel sync control block
// Assumes: wishbone ack one cycle after take, counter outputs one cycle after inputs
// Notes: register cases from a table, counter and reset cases by hand
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00, sync_select_o;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [4:0] cnt_wr_i = 5'h00, clr_event_i = 5'h00, cnt_load_o, cnt_clear_o;
    logic [79:0] cnt_wdata_i = 80'h4ABC_3ABC_2ABC_1ABC_0ABC, cnt_load_data_o;
    logic [14:0] clr_src_i = {3'h3, 3'h3, 3'h3, 3'h0, 3'h3};
    int errors = 0;
    int n_compared = 0;
    typedef struct {logic [7:0] wa; logic [3:0] ws; logic [7:0] wd; logic [7:0] ra;
        logic [7:0] rx; logic [7:0] sx;} tsc_row_type;
    tsc_row_type rows [7] = '{
        '{8'h00, 4'h1, 8'hFF, 8'h00, 8'hC7, 8'hC7}, '{8'h00, 4'h1, 8'h38, 8'h00, 8'h00, 8'h00},
        '{8'h00, 4'h1, 8'hC0, 8'h00, 8'hC0, 8'hC0}, '{8'h00, 4'hF, 8'h07, 8'h00, 8'h07, 8'h07},
        '{8'h00, 4'hE, 8'hFF, 8'h00, 8'h07, 8'h07}, '{8'h04, 4'h1, 8'hFF, 8'h04, 8'h00, 8'h07},
        '{8'hFC, 4'h1, 8'hFF, 8'h00, 8'h07, 8'h07}};
    // ----------------------------------------
    // design and clock
    // ----------------------------------------
    tsc_sync_ctrl tsc_sync_ctrl_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cnt_wr_i(cnt_wr_i),
        .cnt_wdata_i(cnt_wdata_i), .clr_src_i(clr_src_i), .clr_event_i(clr_event_i),
        .cnt_load_o(cnt_load_o), .cnt_load_data_o(cnt_load_data_o),
        .cnt_clear_o(cnt_clear_o), .sync_select_o(sync_select_o));
    always #12.5 clk_i = ~clk_i;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1);
        check("ack latency", k, 32'h2);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb
    task automatic ctr(input logic [4:0] wr, clr, fl, eld, ecl, input logic [15:0] ev);
        @(posedge clk_i);
        cnt_wr_i <= wr;
        clr_event_i <= clr;
        @(posedge clk_i);
        cnt_wr_i <= 5'h00;
        clr_event_i <= 5'h00;
        #1;
        check("load pulses", {27'h0, cnt_load_o}, {27'h0, eld});
        check("clear pulses", {27'h0, cnt_clear_o}, {27'h0, ecl});
        for (int n = 0; n < 5; n++) begin
            if (eld[n]) check("load value", {16'h0, cnt_load_data_o[16*n+:16]},
                {16'h0, fl[n] ? ev : cnt_wdata_i[16*n+:16]});
        end
        @(posedge clk_i);
        #1;
        check("pulse end", {27'h0, cnt_load_o | cnt_clear_o}, 32'h0);
    endtask : ctr
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        check("idle outputs", {21'h0, wb_ack_o, cnt_load_o, cnt_clear_o}, 32'h0);
        reset_n_i <= 1'b1;
        wb(1'b0, 8'h00, 4'hF, 32'h0, rd);
        check("reset value", rd, 32'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            wb(1'b1, rows[i].wa, rows[i].ws, {24'h0, rows[i].wd}, rd);
            wb(1'b0, rows[i].ra, 4'hF, 32'h0, rd);
            check("read data", rd, {24'h0, rows[i].rx});
            check("sync copy", {24'h0, sync_select_o}, {24'h0, rows[i].sx});
        end
        $display("test register table done");
        wb(1'b1, 8'h00, 4'h1, 32'hC3, rd);
        ctr(5'b00010, 5'b00000, 5'b11011, 5'b11011, 5'b00000, 16'h1ABC);
        ctr(5'b00001, 5'b00000, 5'b11011, 5'b11011, 5'b00000, 16'h0ABC);
        ctr(5'b11000, 5'b00000, 5'b11011, 5'b11011, 5'b00000, 16'h3ABC);
        ctr(5'b00100, 5'b00000, 5'b11011, 5'b00100, 5'b00000, 16'h0);
        ctr(5'b00000, 5'b00001, 5'b11011, 5'b00000, 5'b11001, 16'h0);
        ctr(5'b00000, 5'b00010, 5'b11011, 5'b00000, 5'b11011, 16'h0);
        ctr(5'b00000, 5'b00100, 5'b11011, 5'b00000, 5'b00100, 16'h0);
        ctr(5'b00101, 5'b01000, 5'b11011, 5'b11111, 5'b11001, 16'h0ABC);
        wb(1'b1, 8'h00, 4'h1, 32'h00, rd);
        ctr(5'b00010, 5'b00001, 5'b00000, 5'b00010, 5'b00001, 16'h0);
        $display("test counter sync done");
        wb(1'b1, 8'h00, 4'h1, 32'hC7, rd);
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        cnt_wr_i <= 5'h1F;
        clr_event_i <= 5'h1F;
        repeat (2) @(posedge clk_i);
        check("reset holds", {22'h0, cnt_load_o, cnt_clear_o}, 32'h0);
        check("reset copy", {24'h0, sync_select_o}, 32'h0);
        reset_n_i <= 1'b1;
        cnt_wr_i <= 5'h00;
        clr_event_i <= 5'h00;
        wb(1'b0, 8'h00, 4'hF, 32'h0, rd);
        check("second reset", rd, 32'h0);
        $display("test second reset done");
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        errors++;
        finish_test();
    end
endmodule : testbench
